//--- shared/cfrc_pkg.sv
// Constants for the acceptance-filter routing bank that covers filters 12 to 23.
// Assumes a 32-bit register port and a receive engine on the same clock.
package cfrc_pkg;

  // Shape of the bank.
  localparam int NUM_FILTERS   = 12;
  localparam int FIRST_FILTER  = 12;
  localparam int LANES_PER_REG = 4;
  localparam int NUM_REGS      = 3;
  localparam int DATA_W        = 32;
  localparam int ADDR_W        = 8;
  localparam int LANE_W        = 8;
  localparam int FILTER_IDX_W  = 5;

  // Field layout inside one byte lane.
  localparam int EN_BIT   = 7;
  localparam int MSEL_LSB = 5;
  localparam int MSEL_W   = 2;
  localparam int FSEL_LSB = 0;
  localparam int FSEL_W   = 5;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] OFF_GROUP_12_15 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_GROUP_16_19 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_GROUP_20_23 = 8'h08;
  localparam logic [ADDR_W-1:0] GROUP_OFF [NUM_REGS] = '{
    OFF_GROUP_12_15,
    OFF_GROUP_16_19,
    OFF_GROUP_20_23
  };

  // Reset values.
  localparam logic              RST_ENABLE  = 1'h0;
  localparam logic [MSEL_W-1:0] RST_MSEL    = 2'h0;
  localparam logic [FSEL_W-1:0] RST_FSEL    = 5'h00;
  localparam logic [DATA_W-1:0] RST_RDATA   = 32'h00000000;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h00000000;

endpackage

//--- design/cfrc_filter_lane.sv
// One filter's settings: enable, mask choice and destination FIFO.
// Assumes the caller decodes the write and presents this filter's byte lane.
`timescale 1ns/1ps
module cfrc_filter_lane (
  input  wire logic                          ref_clk,          // Module clock.
  input  wire logic                          rst_n,            // Async reset, active low.
  input  wire logic                          clkEn,            // Freezes state when low.
  input  wire logic                          wrEn,             // Write this lane.
  input  wire logic [cfrc_pkg::LANE_W-1:0]   wrByte,           // Lane write data.
  output logic                               filterEnable,     // Filter enabled.
  output logic [cfrc_pkg::MSEL_W-1:0]        filterMaskSelect, // Chosen mask.
  output logic [cfrc_pkg::FSEL_W-1:0]        filterFifoSelect  // Destination FIFO.
);
  import cfrc_pkg::*;

  logic              enable_ff;
  logic              nxt_enable;
  logic [MSEL_W-1:0] mask_ff;
  logic [MSEL_W-1:0] nxt_mask;
  logic [FSEL_W-1:0] fifo_ff;
  logic [FSEL_W-1:0] nxt_fifo;

  always_comb begin
    nxt_enable = enable_ff;
    nxt_mask   = mask_ff;
    nxt_fifo   = fifo_ff;
    if (wrEn) begin
      nxt_enable = wrByte[EN_BIT];
      // The old enable decides, so one write may both configure and enable.
      if (!enable_ff) begin
        nxt_mask = wrByte[MSEL_LSB +: MSEL_W];
        nxt_fifo = wrByte[FSEL_LSB +: FSEL_W];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff <= RST_ENABLE;
      mask_ff   <= RST_MSEL;
      fifo_ff   <= RST_FSEL;
    end else if (clkEn) begin
      enable_ff <= nxt_enable;
      mask_ff   <= nxt_mask;
      fifo_ff   <= nxt_fifo;
    end
  end

  assign filterEnable     = enable_ff;
  assign filterMaskSelect = mask_ff;
  assign filterFifoSelect = fifo_ff;

endmodule

//--- design/cfrc_filter_routing_control.sv
// Routing bank for acceptance filters 12 to 23: three registers of settings
// and the selection of a destination FIFO from the comparator hits.
// Assumes a register master on ref_clk and a comparator that delivers one
// hit vector per message on the same clock, so no input is synchronised.
//
// How it works
// - Each filter has one enable bit, one puts it into matching and zero takes it out.
// - Each filter has a two-bit mask choice where codes 0 to 3 pick masks 0 to 3.
// - Each filter has a five-bit destination that names FIFO 0 to FIFO 31.
// - Each register holds four filters, one per byte, enable on top, mask next, FIFO low.
// - Filters rise through the registers four at a time, lowest filter in the lowest byte.
// - Reset clears every setting, so all filters are off, on mask 0 and on FIFO 0.
// - Every setting bit reads back as last taken by the filter, or zero after reset.
// - Mask and FIFO of a filter change only while it is off, and writes to them are ignored else.
//
// Register port timing.
// A write is taken at the rising edge where regWrStrobe and clkEn are both high.
// The new settings show on the filter outputs from the cycle after that edge.
// A read is taken the same way with regRdStrobe, and its data stand on regRdData
// for exactly the following cycle; in every other cycle regRdData is zero.
// Strobes may follow each other with no gap, but never stand together.
// Writes and reads to an address outside the three groups are dropped and read
// back as zero, so software sees no error for a stray access.
//
// Register map.
// Offset 0x00 holds filters 12 to 15, 0x04 holds 16 to 19, 0x08 holds 20 to 23.
// Byte k of a group belongs to the group's first filter plus k.
// Only whole words are written; there are no byte enables on this port.
//
// Reconfiguration.
// The lock on mask and FIFO looks at the enable held before the write.
// Writing enable one together with new fields to an idle filter takes them all,
// so software may configure and arm a filter in a single access.
// Writing enable zero together with new fields to a live filter only disarms it;
// the old fields survive and a second write is needed to change them.
// This keeps a half-written word from retargeting a filter while it matches.
//
// Routing.
// The comparator hands over one hit vector per message with hitValid high.
// Raw hits are gated with the enables before the priority pick, so a disabled
// filter can never win even if the comparator reports it.
// The lowest-numbered enabled filter that hits wins the message.
// One cycle later either routeValid or routeMiss pulses for one cycle.
// routeFifo, routeMask and routeFilter keep the last winner until the next one,
// which lets a slow consumer pick them up after the pulse has gone.
// Settings are sampled in the cycle of hitValid, so a write in that same cycle
// only affects the next message.
//
// Clock enable.
// With clkEn low every flop holds, including the one-cycle pulses, which then
// stretch until clkEn returns.
// Strobes and hits that arrive while clkEn is low are lost.
`timescale 1ns/1ps
module cfrc_filter_routing_control (
  input  wire logic                                       ref_clk,          // Module clock.
  input  wire logic                                       rst_n,            // Async reset.
  input  wire logic                                       clkEn,            // Clock enable.
  input  wire logic [cfrc_pkg::ADDR_W-1:0]                regAddr,          // Byte address.
  input  wire logic [cfrc_pkg::DATA_W-1:0]                regWrData,        // Write data.
  input  wire logic                                       regWrStrobe,      // Write strobe.
  input  wire logic                                       regRdStrobe,      // Read strobe.
  output logic      [cfrc_pkg::DATA_W-1:0]                regRdData,        // Read data.
  output logic      [cfrc_pkg::NUM_FILTERS-1:0]           filterEnable,     // Enables.
  output logic      [cfrc_pkg::NUM_FILTERS-1:0]
                    [cfrc_pkg::MSEL_W-1:0]                filterMaskSelect, // Mask picks.
  output logic      [cfrc_pkg::NUM_FILTERS-1:0]
                    [cfrc_pkg::FSEL_W-1:0]                filterFifoSelect, // FIFO picks.
  input  wire logic                                       hitValid,         // Hits present.
  input  wire logic [cfrc_pkg::NUM_FILTERS-1:0]           hitVec,           // Raw hits.
  output logic                                            routeValid,       // Routed pulse.
  output logic                                            routeMiss,        // No filter pulse.
  output logic      [cfrc_pkg::FSEL_W-1:0]                routeFifo,        // Target FIFO.
  output logic      [cfrc_pkg::MSEL_W-1:0]                routeMask,        // Winner's mask.
  output logic      [cfrc_pkg::FILTER_IDX_W-1:0]          routeFilter       // Winner number.
);
  import cfrc_pkg::*;

  // Write decode.

  logic [NUM_FILTERS-1:0] laneWr;

  always_comb begin
    laneWr = '0;
    for (int g = 0; g < NUM_REGS; g++) begin
      if (regWrStrobe && (regAddr == GROUP_OFF[g])) begin
        for (int k = 0; k < LANES_PER_REG; k++) begin
          laneWr[g*LANES_PER_REG + k] = 1'b1;
        end
      end
    end
  end

  // Filter settings, one lane per filter.

  for (genvar i = 0; i < NUM_FILTERS; i++) begin : gLane
    localparam int LANE = i % LANES_PER_REG;
    cfrc_filter_lane uLane (
      .ref_clk          (ref_clk),
      .rst_n            (rst_n),
      .clkEn            (clkEn),
      .wrEn             (laneWr[i]),
      .wrByte           (regWrData[LANE*LANE_W +: LANE_W]),
      .filterEnable     (filterEnable[i]),
      .filterMaskSelect (filterMaskSelect[i]),
      .filterFifoSelect (filterFifoSelect[i])
    );
  end

  // Read path: data stand for the single cycle after the strobe.

  logic [DATA_W-1:0] rdData_ff;
  logic [DATA_W-1:0] nxt_rdData;
  logic [LANE_W-1:0] laneByte;

  always_comb begin
    nxt_rdData = RST_RDATA;
    laneByte   = '0;
    if (regRdStrobe) begin
      nxt_rdData = UNMAPPED_RD;
      for (int g = 0; g < NUM_REGS; g++) begin
        if (regAddr == GROUP_OFF[g]) begin
          for (int k = 0; k < LANES_PER_REG; k++) begin
            laneByte = {filterEnable[g*LANES_PER_REG + k],
                        filterMaskSelect[g*LANES_PER_REG + k],
                        filterFifoSelect[g*LANES_PER_REG + k]};
            nxt_rdData[k*LANE_W +: LANE_W] = laneByte;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= RST_RDATA;
    end else if (clkEn) begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;

  // Routing: the lowest-numbered enabled filter that hits wins the message.
  // A raw hit on a disabled filter is dropped before the priority pick, so a
  // comparator that does not gate its own hits cannot leak a stale route.

  logic                    routeValid_ff;
  logic                    nxt_routeValid;
  logic                    routeMiss_ff;
  logic                    nxt_routeMiss;
  logic [FSEL_W-1:0]       routeFifo_ff;
  logic [FSEL_W-1:0]       nxt_routeFifo;
  logic [MSEL_W-1:0]       routeMask_ff;
  logic [MSEL_W-1:0]       nxt_routeMask;
  logic [FILTER_IDX_W-1:0] routeFilter_ff;
  logic [FILTER_IDX_W-1:0] nxt_routeFilter;
  logic [NUM_FILTERS-1:0]  liveHit;
  logic                    found;
  logic [FILTER_IDX_W-1:0] winIdx;

  // Priority pick: scanning from the top leaves the lowest live hit in winIdx.
  always_comb begin
    liveHit = hitVec & filterEnable;
    found   = 1'b0;
    winIdx  = '0;
    for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
      if (liveHit[i]) begin
        found  = 1'b1;
        winIdx = FILTER_IDX_W'(i);
      end
    end
  end

  always_comb begin
    nxt_routeValid  = 1'b0;
    nxt_routeMiss   = 1'b0;
    nxt_routeFifo   = routeFifo_ff;
    nxt_routeMask   = routeMask_ff;
    nxt_routeFilter = routeFilter_ff;
    if (hitValid) begin
      if (found) begin
        nxt_routeFifo   = filterFifoSelect[winIdx];
        nxt_routeMask   = filterMaskSelect[winIdx];
        nxt_routeFilter = FILTER_IDX_W'(FIRST_FILTER) + winIdx;
      end
      nxt_routeValid = found;
      nxt_routeMiss  = !found;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      routeValid_ff  <= 1'b0;
      routeMiss_ff   <= 1'b0;
      routeFifo_ff   <= RST_FSEL;
      routeMask_ff   <= RST_MSEL;
      routeFilter_ff <= '0;
    end else if (clkEn) begin
      routeValid_ff  <= nxt_routeValid;
      routeMiss_ff   <= nxt_routeMiss;
      routeFifo_ff   <= nxt_routeFifo;
      routeMask_ff   <= nxt_routeMask;
      routeFilter_ff <= nxt_routeFilter;
    end
  end

  assign routeValid  = routeValid_ff;
  assign routeMiss   = routeMiss_ff;
  assign routeFifo   = routeFifo_ff;
  assign routeMask   = routeMask_ff;
  assign routeFilter = routeFilter_ff;

endmodule

//--- verif/cfrc_chk.sv
// Checker for the filter routing bank: register port, settings and routing pulses.
// Assumes it is bound to the bank's top module and sees only its ports.
`timescale 1ns/1ps
module cfrc_chk import cfrc_pkg::*; (
  input wire logic                               ref_clk,
  input wire logic                               rst_n,
  input wire logic                               clkEn,
  input wire logic [ADDR_W-1:0]                  regAddr,
  input wire logic [DATA_W-1:0]                  regWrData,
  input wire logic                               regWrStrobe,
  input wire logic                               regRdStrobe,
  input wire logic [DATA_W-1:0]                  regRdData,
  input wire logic [NUM_FILTERS-1:0]             filterEnable,
  input wire logic [NUM_FILTERS-1:0][MSEL_W-1:0] filterMaskSelect,
  input wire logic [NUM_FILTERS-1:0][FSEL_W-1:0] filterFifoSelect,
  input wire logic                               hitValid,
  input wire logic [NUM_FILTERS-1:0]             hitVec,
  input wire logic                               routeValid,
  input wire logic                               routeMiss,
  input wire logic [FSEL_W-1:0]                  routeFifo,
  input wire logic [FILTER_IDX_W-1:0]            routeFilter
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire       wr    = clkEn && regWrStrobe;
  wire       rd    = clkEn && regRdStrobe;
  wire [3:0] wrEn4 = {regWrData[31], regWrData[23], regWrData[15], regWrData[7]};
  wire [3:0] rdEn4 = {regRdData[31], regRdData[23], regRdData[15], regRdData[7]};
  property p_rd_idle; clkEn && !regRdStrobe |=> regRdData == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmap; rd && !(regAddr inside {8'h00, 8'h04, 8'h08}) |=> regRdData == '0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rd_en; rd && regAddr == 8'h00 |=> rdEn4 == $past(filterEnable[3:0]); endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");
  property p_wr_en; wr && regAddr == 8'h04 |=> filterEnable[7:4] == $past(wrEn4); endproperty
  a_wr_en: assert property (p_wr_en) else $error("enable write wrong");
  property p_wr_fld;
    wr && regAddr == 8'h08 && !filterEnable[11] |=> filterFifoSelect[11] ==
      $past(regWrData[28:24]) && filterMaskSelect[11] == $past(regWrData[30:29]);
  endproperty
  a_wr_fld: assert property (p_wr_fld) else $error("field write wrong");
  property p_lock;
    wr && regAddr == 8'h00 && filterEnable[0] |=>
      $stable(filterFifoSelect[0]) && $stable(filterMaskSelect[0]);
  endproperty
  a_lock: assert property (p_lock) else $error("enabled filter changed");
  property p_miss; clkEn && hitValid && (hitVec & filterEnable) == '0 |=> routeMiss && !routeValid;
  endproperty
  a_miss: assert property (p_miss) else $error("disabled hit routed");
  property p_route;
    clkEn && hitValid && hitVec[0] && filterEnable[0] |=> routeValid && routeFilter == 5'h0C &&
      routeFifo == $past(filterFifoSelect[0]);
  endproperty
  a_route: assert property (p_route) else $error("filter 12 hit misrouted");
  cover property (wr && regAddr == 8'h00 && filterEnable[0]);
  cover property (clkEn && hitValid ##1 routeValid);
  cover property (routeMiss);
endmodule
bind cfrc_filter_routing_control cfrc_chk cfrc_chk_inst (.*);

//--- verif/cfrc_rx_model.sv
// Receive-engine stand-in: turns one request into a one-cycle hit vector.
// Assumes the bench raises fire for one cycle with the hit pattern beside it.
`timescale 1ns/1ps
module cfrc_rx_model import cfrc_pkg::*; (
  input  wire logic                   ref_clk,          // Module clock.
  input  wire logic                   fire,             // Present one message.
  input  wire logic [NUM_FILTERS-1:0] pat,              // Hits to present.
  output logic                        hitValid = 1'b0,  // Hits present.
  output logic [NUM_FILTERS-1:0]      hitVec = 12'h000  // Raw hits.
);
  // Idle hit lines toggle so a stale vector can never pass for a live one.
  always @(posedge ref_clk) begin
    hitValid <= fire;
    hitVec   <= fire ? pat : ~hitVec;
  end
endmodule

//--- verif/cfrc_filter_routing_control_tb.sv
// Bench for the filter routing bank: register tasks, routing checks, verdict.
// Assumes the checker binds itself and the receive model supplies hits.
`timescale 1ns/1ps
module cfrc_filter_routing_control_tb;
  import cfrc_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, fire = 1'b0;
  logic regWrStrobe = 1'b0, regRdStrobe = 1'b0, hitValid, routeValid, routeMiss;
  logic [ADDR_W-1:0] regAddr = 8'h00;
  logic [DATA_W-1:0] regWrData = 32'h00000000, regRdData;
  logic [NUM_FILTERS-1:0] filterEnable, hitVec, pat = 12'h000;
  logic [NUM_FILTERS-1:0][MSEL_W-1:0] filterMaskSelect;
  logic [NUM_FILTERS-1:0][FSEL_W-1:0] filterFifoSelect;
  logic [FSEL_W-1:0] routeFifo;
  logic [MSEL_W-1:0] routeMask;
  logic [FILTER_IDX_W-1:0] routeFilter;
  int mismatches = 0, n_tests = 0, cycles = 0;
  cfrc_filter_routing_control cfrc_filter_routing_control_inst (.*);
  cfrc_rx_model cfrc_rx_model_inst (.*);
  initial forever #20 ref_clk = ~ref_clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      $display("ERROR at %0t: timeout", $time);
      summarize();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWrStrobe <= 1'b1;
    regAddr     <= a;
    regWrData   <= d;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    regRdStrobe <= 1'b1;
    regAddr     <= a;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1 chk(regRdData, exp, what);
  endtask
  // The expected word packs valid, miss, filter number, FIFO and mask.
  task automatic hit(input logic [11:0] p, input logic [13:0] exp, input string what);
    @(posedge ref_clk);
    fire <= 1'b1;
    pat  <= p;
    @(posedge ref_clk);
    fire <= 1'b0;
    @(posedge ref_clk);
    #1 chk(32'({routeValid, routeMiss, routeFilter, routeFifo, routeMask}), 32'(exp), what);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) begin
      rd(GROUP_OFF[i], RST_RDATA, "reset value");
    end
    chk(32'(filterEnable), 32'h00000000, "reset enables");
    $display("test reset done");
    wr(8'h00, 32'hFF5FA081);
    wr(8'h04, 32'hFFFFFFFF);
    wr(8'h08, 32'hC5000000);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h00, 32'hFF5FA081, "group 12");
    rd(8'h04, 32'hFFFFFFFF, "group 16");
    rd(8'h08, 32'hC5000000, "group 20");
    rd(8'h0C, UNMAPPED_RD, "unmapped");
    chk(32'({filterEnable, filterMaskSelect[3], filterFifoSelect[2]}),
        32'({12'h8FB, 2'h3, 5'h1F}), "lane fields");
    $display("test registers done");
    hit(12'h009, {1'b1, 1'b0, 5'h0C, 5'h01, 2'h0}, "route 12");
    hit(12'h004, {1'b0, 1'b1, 5'h0C, 5'h01, 2'h0}, "miss");
    hit(12'h804, {1'b1, 1'b0, 5'h17, 5'h05, 2'h2}, "route 23");
    $display("test routing done");
    // A write with the clock enable low must be lost.
    @(posedge ref_clk);
    clkEn <= 1'b0;
    wr(8'h04, 32'h00000000);
    clkEn <= 1'b1;
    rd(8'h04, 32'hFFFFFFFF, "frozen write");
    $display("test clock enable done");
    // Software clears the enable first and only then rewrites the fields.
    wr(8'h00, 32'h00000000);
    rd(8'h00, 32'h7F002001, "locked fields");
    wr(8'h00, 32'h00000000);
    rd(8'h00, 32'h00000000, "cleared");
    hit(12'h001, {1'b0, 1'b1, 5'h17, 5'h05, 2'h2}, "disabled");
    $display("test lock done");
    summarize();
  end
endmodule
